// [core/bbsram_host.sv]
// Host controller driving a battery-backed static memory through its pins.
`timescale 1ns/1ps
`default_nettype none
module bbsram_host #(
  parameter int unsigned PROT_RELEASE_CYC = bbsram_pkg::PROT_RELEASE_CYC
) (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // User request
  input  wire logic                          i_req_valid,
  input  wire bbsram_pkg::bbsram_req_t       i_req,
  output logic                               o_req_ready,
  output logic                               o_rd_valid,
  output logic [bbsram_pkg::DATA_W-1:0]      o_rd_data,
  output logic                               o_power_fail,
  output logic                               o_battery_low,
  // Memory pins
  output var bbsram_pkg::bbsram_ctl_t        o_ctl,
  output logic [bbsram_pkg::ADDR_W-1:0]      o_address_lines,
  input  wire logic [bbsram_pkg::DATA_W-1:0] i_data_lines,
  output logic [bbsram_pkg::DATA_W-1:0]      o_data_lines,
  output logic                               o_data_lines_oe,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_battery_low_warning_n
);
  typedef enum logic [2:0] {S_HOLD, S_IDLE, S_RD, S_WR, S_RECOV} bbsram_state_t;

  bbsram_state_t state_q;
  logic [3:0]    cnt_q;
  logic [20:0]   hold_q;
  logic [1:0]    pins_s;
  logic          rst_n_s;
  logic          bw_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // The open-drain pins are never driven by us; they only come in here.
  bbsram_sync #(.W(2)) bbsram_sync_inst (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_reset_n, i_battery_low_warning_n}),
    .o_sync  (pins_s)
  );
  assign rst_n_s = pins_s[1];
  assign bw_n_s  = pins_s[0];

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_power_fail  <= 1'b1;
      o_battery_low <= 1'b0;
    end
    else
    begin
      o_power_fail  <= ~rst_n_s;
      o_battery_low <= ~bw_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold-off after reset releases; the device may still protect itself, so we
  // wait the full release time rather than trust the reset pin alone.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      hold_q <= '0;
    else if (!rst_n_s)
      hold_q <= '0;
    else if (hold_q != 21'(PROT_RELEASE_CYC))
      hold_q <= hold_q + 21'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= S_HOLD;
      cnt_q   <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        S_HOLD:
          if (rst_n_s && hold_q == 21'(PROT_RELEASE_CYC))
            state_q <= S_IDLE;
        S_IDLE:
          if (!rst_n_s)
            state_q <= S_HOLD;
          else if (i_req_valid)
          begin
            state_q <= i_req.wr ? S_WR : S_RD;
            cnt_q   <= i_req.wr ? 4'(bbsram_pkg::WRITE_CYC) : 4'(bbsram_pkg::READ_CYC);
          end
        S_RD, S_WR:
          if (cnt_q == 4'h1)
          begin
            state_q <= S_RECOV;
            cnt_q   <= 4'(bbsram_pkg::RECOV_CYC);
          end
          else
            cnt_q <= cnt_q - 4'h1;
        S_RECOV:
          if (cnt_q == 4'h1)
            state_q <= rst_n_s ? S_IDLE : S_HOLD;
          else
            cnt_q <= cnt_q - 4'h1;
      endcase
    end
  end

  assign o_req_ready = (state_q == S_IDLE) && rst_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from flops. Address and data are latched once per access so
  // they stay steady through the whole strobe.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ctl           <= '{select_n: 1'b1, strobe_n: 1'b1, gate_n: 1'b1};
      o_address_lines <= '0;
      o_data_lines    <= '0;
      o_data_lines_oe <= 1'b0;
    end
    else
    begin
      if (o_req_ready && i_req_valid)
      begin
        o_address_lines <= i_req.addr;
        o_data_lines    <= i_req.wdata;
        o_ctl.select_n  <= 1'b0;
        o_ctl.strobe_n  <= ~i_req.wr;
        o_ctl.gate_n    <= i_req.wr;
        o_data_lines_oe <= i_req.wr;
      end
      else if ((state_q == S_RD || state_q == S_WR) && cnt_q == 4'h1)
      begin
        o_ctl           <= '{select_n: 1'b1, strobe_n: 1'b1, gate_n: 1'b1};
        o_data_lines_oe <= 1'b0;
      end
    end
  end

  // Sample read data at the last cycle, which covers both access delays.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end
    else
    begin
      o_rd_valid <= (state_q == S_RD) && cnt_q == 4'h1;
      if ((state_q == S_RD) && cnt_q == 4'h1)
        o_rd_data <= i_data_lines;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_no_contention;
    @(posedge i_clk) disable iff (i_rst)
    o_data_lines_oe |-> o_ctl.gate_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("gate low while driving");

  // The strobe is low for a single cycle, so the address is held through its rise.
  property p_addr_stable;
    @(posedge i_clk) disable iff (i_rst)
    (!o_ctl.strobe_n) |=> $stable(o_address_lines);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

  sequence s_strobe_rise;
    !o_ctl.strobe_n ##1 o_ctl.strobe_n;
  endsequence
  property p_recovery;
    @(posedge i_clk) disable iff (i_rst)
    s_strobe_rise |-> o_ctl.select_n [*1] ##1 o_ctl.select_n;
  endproperty
  a_recovery: assert property (p_recovery) else $error("recovery gap too short");

  property p_read_shape;
    @(posedge i_clk) disable iff (i_rst)
    (!o_ctl.gate_n) |-> (!o_ctl.select_n && o_ctl.strobe_n);
  endproperty
  a_read_shape: assert property (p_read_shape) else $error("bad read pin state");

  property p_write_shape;
    @(posedge i_clk) disable iff (i_rst)
    (!o_ctl.strobe_n) |-> (!o_ctl.select_n && o_data_lines_oe);
  endproperty
  a_write_shape: assert property (p_write_shape) else $error("bad write pin state");

  property p_read_len;
    @(posedge i_clk) disable iff (i_rst)
    $fell(o_ctl.gate_n) |-> (!o_ctl.gate_n) [*2] ##1 o_ctl.gate_n ##0 o_rd_valid;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read length wrong");

  property p_hold_off;
    @(posedge i_clk) disable iff (i_rst)
    (!rst_n_s) |=> !o_req_ready;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("ready during device reset");

  property p_fail_flag;
    @(posedge i_clk) disable iff (i_rst)
    (!rst_n_s) |=> o_power_fail;
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("power fail not flagged");
endmodule // bbsram_host
`default_nettype wire

// [shared/bbsram_pkg.sv]
// Package for the battery-backed memory host controller: widths, timing and carrier types.
`default_nettype none
package bbsram_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  // Device access figures in ns, slow grade.
  localparam int unsigned ADDR_TO_DATA_NS = 100;
  localparam int unsigned SELECT_TO_DATA_NS = 100;
  localparam int unsigned GATE_TO_DATA_NS = 50;
  localparam int unsigned WRITE_PULSE_NS = 75;
  localparam int unsigned STROBE_RECOVERY_NS = 35;
  localparam int unsigned STROBE_TO_FLOAT_NS = 35;
  // Least times round up to whole cycles; the read count takes one cycle more.
  localparam int unsigned READ_CYC =
    (((ADDR_TO_DATA_NS > SELECT_TO_DATA_NS) ? ADDR_TO_DATA_NS : SELECT_TO_DATA_NS)
     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOV_CYC =
    (STROBE_RECOVERY_NS + STROBE_TO_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Protection release after supply valid, in ms, and the host hold-off.
  localparam int unsigned PROT_RELEASE_MS = 125;
  localparam int unsigned PROT_RELEASE_CYC = PROT_RELEASE_MS * 10000;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef struct packed {
    logic             wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bbsram_req_t;

  typedef struct packed {
    logic select_n;
    logic strobe_n;
    logic gate_n;
  } bbsram_ctl_t;
endpackage
`default_nettype wire

// [core/bbsram_sync.sv]
// Two-flop synchroniser for the open-drain status pins.
`timescale 1ns/1ps
`default_nettype none
module bbsram_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  // Pins idle high through their pull-ups.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= '1;
      o_sync <= '1;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // bbsram_sync
`default_nettype wire

// [verification/bbsram_mem_model.sv]
// Behavioural battery-backed memory seen by the host controller.
`timescale 1ns/1ps
`default_nettype none
module bbsram_mem_model #(
  // Cycles the reset pin stays low after the supply returns; a short stand-in.
  parameter int unsigned RST_HOLD_CYC = 10
) (
  // Memory pins
  input  wire logic                    i_clk,
  input  wire bbsram_pkg::bbsram_ctl_t i_ctl,
  input  wire logic [14:0]             i_address_lines,
  input  wire logic [7:0]              i_bus,
  output logic      [7:0]              o_data_lines,
  // Supply and cell conditions
  input  wire logic                    i_supply_ok,
  input  wire logic                    i_cell_weak,
  output logic                         o_reset_pull,
  output logic                         o_warning_pull
);
  logic [7:0] mem [0:32767];
  logic [7:0] last_q = 8'h00;
  logic       warn_q = 1'b0;
  logic       sup_q = 1'b0;
  logic       drive;
  logic       prot;
  int unsigned hold_cnt = 0;
  // Writes stay blocked and inputs ignored until the reset pin is released.
  assign prot = !i_supply_ok || hold_cnt < RST_HOLD_CYC;
  assign drive = !prot && !i_ctl.select_n && !i_ctl.gate_n && i_ctl.strobe_n;
  // Released lines show the inverse of the last byte, so a stale value never passes.
  assign o_data_lines = drive ? mem[i_address_lines] : ~last_q;
  assign o_reset_pull = prot;
  assign o_warning_pull = warn_q;
  always @(posedge i_clk)
  begin
    last_q <= o_data_lines;
    if (!prot && !i_ctl.select_n && !i_ctl.strobe_n)
      mem[i_address_lines] <= i_bus;
  end
  always @(posedge i_clk)
  begin
    sup_q <= i_supply_ok;
    if (!i_supply_ok)
      hold_cnt <= 0;
    else if (hold_cnt < RST_HOLD_CYC)
      hold_cnt <= hold_cnt + 1;
    if (i_supply_ok && !sup_q)
      warn_q <= i_cell_weak;
    else if (!prot && i_cell_weak)
      warn_q <= 1'b1;
  end
endmodule // bbsram_mem_model
`default_nettype wire

// [verification/bbsram_host_tb_top.sv]
// Self-checking bench for the battery-backed memory host controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module bbsram_host_tb_top;
  logic                    i_clk = 1'b0;
  logic                    i_rst = 1'b1;
  logic                    i_req_valid = 1'b0;
  bbsram_pkg::bbsram_req_t i_req = '0;
  logic                    supply_ok = 1'b0;
  logic                    cell_weak = 1'b0;
  logic                    ready, rd_valid, pfail, blow, oe, rst_pull, warn_pull;
  bbsram_pkg::bbsram_ctl_t ctl;
  logic [14:0]             addr;
  logic [7:0]              rd_data, hdata, mdata, bus, exp_v;
  logic [7:0]              exp_q [$];
  logic [7:0]              shadow [logic [14:0]];
  logic [14:0]             used [$];
  int                      n_errors = 0;
  int                      total_checks = 0;
  always #50 i_clk = ~i_clk;
  assign bus = oe ? hdata : mdata;
  bbsram_host #(.PROT_RELEASE_CYC(20)) bbsram_host_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .o_power_fail(pfail), .o_battery_low(blow), .o_ctl(ctl), .o_address_lines(addr),
    .i_data_lines(bus), .o_data_lines(hdata), .o_data_lines_oe(oe),
    .i_reset_n(!rst_pull), .i_battery_low_warning_n(!warn_pull));
  bbsram_mem_model bbsram_mem_model_inst (
    .i_clk(i_clk), .i_ctl(ctl), .i_address_lines(addr), .i_bus(bus),
    .o_data_lines(mdata), .i_supply_ok(supply_ok), .i_cell_weak(cell_weak),
    .o_reset_pull(rst_pull), .o_warning_pull(warn_pull));
  task complete_run;
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    i_req_valid = 1'b1;
    i_req = '{wr: wr, addr: a, wdata: d};
    while (ready !== 1'b1 && n < 80)
    begin
      @(negedge i_clk);
      n++;
    end
    `CHK("ready_wait", 1'b1, ready)
    if (wr)
      shadow[a] = d;
    else
      exp_q.push_back(shadow[a]);
    @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask
  // Read results are compared against the oldest queued expectation.
  always @(negedge i_clk)
    if (rd_valid === 1'b1)
    begin
      exp_v = exp_q.pop_front();
      `CHK("rd_data", exp_v, rd_data)
    end
  initial
  begin
    #(100 * 5000);
    n_errors++;
    complete_run();
  end
  initial
  begin
    void'($urandom(83413));
    repeat (6) @(negedge i_clk);
    `CHK("ctl_in_reset", 3'h7, ctl)
    i_rst = 1'b0;
    repeat (30) @(negedge i_clk);
    `CHK("ready_held", 1'b0, ready)
    `CHK("power_fail", 1'b1, pfail)
    supply_ok = 1'b1;
    repeat (6) @(negedge i_clk);
    `CHK("ready_in_rec", 1'b0, ready)
    `CHK("power_fail_rec", 1'b1, pfail)
    for (int i = 0; i < 10; i++)
    begin
      used.push_back(i == 0 ? 15'h0000 : i == 1 ? 15'h7fff : 15'($urandom));
      access(1'b1, used[i], 8'($urandom));
    end
    foreach (used[i]) access(1'b0, used[i], 8'h00);
    cell_weak = 1'b1;
    repeat (4) @(negedge i_clk);
    `CHK("battery_low", 1'b1, blow)
    cell_weak = 1'b0;
    repeat (4) @(negedge i_clk);
    `CHK("battery_latched", 1'b1, blow)
    supply_ok = 1'b0;
    repeat (4) @(negedge i_clk);
    `CHK("power_fail_again", 1'b1, pfail)
    `CHK("ready_in_fail", 1'b0, ready)
    supply_ok = 1'b1;
    access(1'b0, used[1], 8'h00);
    access(1'b0, used[0], 8'h00);
    `CHK("battery_retest", 1'b0, blow)
    repeat (6) @(negedge i_clk);
    `CHK("queue_empty", 0, exp_q.size())
    complete_run();
  end
endmodule // bbsram_host_tb_top
`default_nettype wire
